/* test/wred_drop_control_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module wred_drop_control_bench;
  import wdc_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, pc, mc, thr, mul;
  logic [2:0] sel_port, pkt_port;
  logic [1:0] sel_queue, pkt_queue, pkt_colour, c;
  logic pkt_valid, pkt_srp, dec_valid, dec_drop, err, sat, s, e;
  logic [10:0] pkt_q_depth, mem_depth, d;
  int miscompares, checked, p, q, idx, cnt, pm_exp;
  int qavg [28];

  wred_drop_control #(.NPORT(7), .NQ(4)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sel_port(sel_port),
    .sel_queue(sel_queue), .pkt_valid(pkt_valid), .pkt_port(pkt_port),
    .pkt_queue(pkt_queue), .pkt_colour(pkt_colour), .pkt_srp(pkt_srp),
    .pkt_q_depth(pkt_q_depth), .mem_depth(mem_depth),
    .dec_valid(dec_valid), .dec_drop(dec_drop));

  task automatic final_report();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // The idle gap before setup also covers the write-to-read spacing of
  // indexed entries and the pointer settling time.
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] dw);
    int n;
    repeat (2) @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= dw;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) begin
      miscompares++;
      final_report();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  function automatic logic exp_drop(input logic [31:0] pcv,
      input logic [31:0] mcv, input logic [1:0] cv, input logic sv,
      input logic hit);
    logic ok;
    ok = !mcv[29] && !(mcv[28] && cv != 2'h0) && !(mcv[27] && cv == 2'h2);
    return pcv[0] & mcv[31] & ok & (!sv | pcv[2]) & hit;
  endfunction

  task automatic send(input logic [1:0] cv, input logic sv,
                      input logic [10:0] dv, input logic ev);
    int n;
    @(posedge pclk);
    pkt_valid <= 1'b1;
    pkt_colour <= cv;
    pkt_srp <= sv;
    pkt_q_depth <= dv;
    @(posedge pclk);
    pkt_valid <= 1'b0;
    n = 0;
    do begin
      @(posedge pclk);
      #1;
      n++;
    end while (dec_valid !== 1'b1 && n < 8);
    check(dec_valid, 1'b1);
    check(dec_drop, ev);
    if (n >= 8)
      final_report();
  endtask

  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  // Reference for the shared memory average, stepped on every clock.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      pm_exp <= 0;
    else
      pm_exp <= pm_exp + ((int'(mem_depth) - pm_exp) >>> 3);
  end

  initial begin
    #(100 * 60000);
    miscompares++;
    final_report();
  end

  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, pkt_valid, pkt_srp} = '0;
    {paddr, pwdata, sel_port, sel_queue, pkt_port, pkt_queue} = '0;
    {pkt_colour, pkt_q_depth, mem_depth} = '0;
    miscompares = 0;
    checked = 0;
    foreach (qavg[i]) qavg[i] = 0;
    void'($urandom(27));
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, WDC_PM_THR_OFS, '0); check(rd, 32'h0400_0080);
    apb(1'b0, WDC_PM_MUL_OFS, '0); check(rd, 32'h0020_0000);
    apb(1'b1, WDC_PM_MUL_OFS, 32'h07FF_07FF);
    apb(1'b0, WDC_PM_MUL_OFS, '0); check(rd, 32'h07FF_0000);
    // Full-scale shared memory thresholds keep its random drops out.
    apb(1'b1, WDC_PM_THR_OFS, 32'h07FF_07FF);
    apb(1'b0, WDC_PM_THR_OFS, '0); check(rd, 32'h07FF_07FF);
    apb(1'b0, WDC_Q_THR_OFS, '0); check(rd, 32'h0080_0009);
    apb(1'b0, WDC_Q_MUL_OFS, '0); check(rd, 32'h0010_0000);
    apb(1'b0, WDC_MON_OFS, '0); check(rd, '0);
    apb(1'b0, 12'h800, '0); check(rd, '0);
    check(err, 1'b1);
    $display("test reset_and_decode done");
    // Saturated entries drop on every allowed packet, the others never do,
    // so the outcome does not depend on the internal random source.
    for (int it = 0; it < 24; it++) begin
      p = $urandom_range(6, 0);
      q = $urandom_range(3, 0);
      idx = p * 4 + q;
      sat = 1'($urandom_range(1, 0));
      mem_depth <= 11'($urandom_range(11'h7F0, 11'h000));
      sel_port <= 3'(p);
      sel_queue <= 2'(q);
      pkt_port <= 3'(p);
      pkt_queue <= 2'(q);
      pc = $urandom & 32'h0000_0704;
      pc[0] = ($urandom_range(3, 0) != 0);
      mc = $urandom & 32'h3C00_0000;
      mc[30] = 1'b0;
      mc[31] = ($urandom_range(3, 0) != 0);
      if (sat)
        mc[26] = 1'b1;
      thr = sat ? 32'h0 : 32'h07FF_07FF;
      mul = sat ? 32'h07FF_0000 : ($urandom & 32'h07FF_0000);
      apb(1'b1, WDC_POLICE_OFS, pc);
      apb(1'b0, WDC_POLICE_OFS, '0); check(rd, pc);
      apb(1'b1, WDC_Q_THR_OFS, thr);
      apb(1'b1, WDC_Q_MUL_OFS, mul | 32'h0000_07FF);
      apb(1'b0, WDC_Q_THR_OFS, '0); check(rd, thr);
      apb(1'b1, WDC_MON_OFS, mc);
      apb(1'b1, WDC_MON_OFS, mc | 32'h4000_0000);
      cnt = 0;
      for (int k = 0; k < 8; k++) begin
        c = 2'($urandom_range(2, 0));
        s = 1'($urandom_range(1, 0));
        d = 11'($urandom_range(11'h7FF, 11'h100));
        qavg[idx] = qavg[idx] + ((int'(d) - qavg[idx]) >>> 3);
        e = exp_drop(pc, mc, c, s, sat);
        send(c, s, d, e);
        case (pc[9:8])
          2'h0: cnt += int'(e);
          2'h1: cnt += int'(c == 2'h0);
          2'h2: cnt += int'(c == 2'h1);
          default: cnt += int'(c == 2'h2);
        endcase
      end
      // A second write with the flush bit still set must not clear.
      apb(1'b1, WDC_MON_OFS, mc | 32'h4000_0000);
      apb(1'b0, WDC_MON_OFS, '0);
      check(rd, mc | 32'h4000_0000 | 32'(cnt));
      apb(1'b0, WDC_Q_MUL_OFS, '0);
      check(rd, mul | 32'(qavg[idx]));
      // The occupancy was set long before, so the average has settled.
      apb(1'b0, WDC_PM_MUL_OFS, '0);
      check(rd, 32'h07FF_0000 | 32'(pm_exp));
      $display("test sweep %0d done", it);
    end
    final_report();
  end
endmodule
`default_nettype wire

/* verilog/wdc_dec_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface wdc_dec_if;
  import wdc_pkg::*;
  logic req;
  wdc_colour_e colour;
  logic stream_reservation_frames;
  logic en;
  logic allow_srp;
  logic gyr_dis;
  logic yr_dis;
  logic r_dis;
  logic q_dall;
  logic pm_dall;
  logic [10:0] q_avg, q_min, q_max, q_mul;
  logic [10:0] pm_avg, pm_min, pm_max, pm_mul;
  logic valid;
  logic drop;
  modport ctl(output req, colour, stream_reservation_frames, en, allow_srp, gyr_dis, yr_dis,
    r_dis, q_dall, pm_dall, q_avg, q_min, q_max, q_mul, pm_avg, pm_min,
    pm_max, pm_mul, input valid, drop);
  modport calc(input req, colour, stream_reservation_frames, en, allow_srp, gyr_dis, yr_dis,
    r_dis, q_dall, pm_dall, q_avg, q_min, q_max, q_mul, pm_avg, pm_min,
    pm_max, pm_mul, output valid, drop);
endinterface
`default_nettype wire

/* verilog/wdc_drop_calc.sv */
`timescale 1ns/1ps
`default_nettype none
module wdc_drop_calc
  import wdc_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Decision request and answer
  wdc_dec_if.calc dec
);
  logic [15:0] lfsr_r;
  logic col_ok;
  logic drop_nxt;
  logic valid_r;
  logic drop_r;

  // Probability is (avg - min) * multiplier against a 16-bit random
  // number, so the chance climbs linearly with occupancy and saturates.
  function automatic logic hit(input logic [10:0] avg, input logic [10:0] mn,
      input logic [10:0] mx, input logic [10:0] mul, input logic dall,
      input logic [15:0] rnd);
    logic [21:0] prob;
    prob = {11'h000, 11'(avg - mn)} * {11'h000, mul};
    // Drop-all is tested first, so a minimum set above the maximum
    // cannot shield a queue that is already past its maximum.
    if (avg > mx && dall) begin
      hit = 1'b1; // R14
    end else if (avg < mn) begin
      hit = 1'b0; // R19
    end else begin
      hit = {6'h00, rnd} < prob; // R19
    end
  endfunction

  always_comb begin
    case (dec.colour)
      WDC_GREEN: col_ok = !dec.gyr_dis; // R11
      WDC_YELLOW: col_ok = !dec.gyr_dis && !dec.yr_dis; // R12
      default: col_ok = !dec.gyr_dis && !dec.yr_dis && !dec.r_dis; // R13
    endcase
  end

  assign drop_nxt = dec.en && col_ok && (!dec.stream_reservation_frames || dec.allow_srp) && // R18
    (hit(dec.q_avg, dec.q_min, dec.q_max, dec.q_mul, dec.q_dall, lfsr_r) ||
     hit(dec.pm_avg, dec.pm_min, dec.pm_max, dec.pm_mul, dec.pm_dall,
       lfsr_r));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lfsr_r <= WDC_LFSR_SEED;
    end else begin
      lfsr_r <= {1'b0, lfsr_r[15:1]} ^ (lfsr_r[0] ? WDC_LFSR_TAPS : 16'h0000);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      valid_r <= 1'b0;
      drop_r <= 1'b0;
    end else begin
      valid_r <= dec.req;
      drop_r <= dec.req && drop_nxt;
    end
  end

  assign dec.valid = valid_r;
  assign dec.drop = drop_r;

  a_gyr_blocks: assert property (@(posedge pclk) disable iff (!presetn) // R11
    dec.req && dec.gyr_dis |=> dec.valid && !dec.drop)
    else $error("packet dropped while all colours are protected");
  a_red_blocks: assert property (@(posedge pclk) disable iff (!presetn) // R13
    dec.req && dec.r_dis && dec.colour == WDC_RED |=> !dec.drop)
    else $error("red packet dropped while red drop is disabled");
  a_drop_all_max: assert property (@(posedge pclk) disable iff (!presetn) // R14
    dec.req && dec.en && dec.colour == WDC_GREEN && !dec.gyr_dis &&
    !dec.stream_reservation_frames && dec.q_dall && dec.q_avg > dec.q_max |=> dec.drop)
    else $error("drop-all above max threshold did not drop");
  a_srp_exempt: assert property (@(posedge pclk) disable iff (!presetn) // R18
    dec.req && dec.stream_reservation_frames && !dec.allow_srp |=> !dec.drop)
    else $error("reservation frame dropped without permission");
endmodule
`default_nettype wire

/* verilog/wdc_mem.sv */
`timescale 1ns/1ps
`default_nettype none
module wdc_mem #(
  parameter int W = 33,
  parameter int D = 28,
  parameter logic [W-1:0] RST = '0
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Write port
  input wire logic we,
  input wire logic [$clog2(D)-1:0] waddr,
  input wire logic [W-1:0] wdata,
  // Registered read ports
  input wire logic [$clog2(D)-1:0] raddr_a,
  output logic [W-1:0] rdata_a,
  input wire logic [$clog2(D)-1:0] raddr_b,
  output logic [W-1:0] rdata_b
);
  generate
    if (D < 2 || W < 1) begin : g_chk
      $error("wdc_mem needs at least two words");
    end
  endgenerate

  logic [W-1:0] mem_r [D];

  // Every entry must come up at its default, so the array is flops.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < D; i++) begin
        mem_r[i] <= RST;
      end
    end else if (we) begin
      mem_r[waddr] <= wdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_a <= '0;
      rdata_b <= '0;
    end else begin
      rdata_a <= mem_r[raddr_a];
      rdata_b <= mem_r[raddr_b];
    end
  end
endmodule
`default_nettype wire

/* verilog/wdc_pkg.sv */
package wdc_pkg;
  localparam int WDC_AW = 12;
  localparam logic [11:0] WDC_POLICE_OFS = 12'h80C;
  localparam logic [11:0] WDC_PM_THR_OFS = 12'h830;
  localparam logic [11:0] WDC_PM_MUL_OFS = 12'h834;
  localparam logic [11:0] WDC_Q_THR_OFS = 12'h840;
  localparam logic [11:0] WDC_Q_MUL_OFS = 12'h844;
  localparam logic [11:0] WDC_MON_OFS = 12'h848;
  localparam int WDC_FW = 11;
  localparam int WDC_HI_LSB = 16;
  localparam int WDC_LO_LSB = 0;
  localparam int WDC_CNT_W = 24;
  localparam int WDC_RDE_BIT = 31;
  localparam int WDC_FLUSH_BIT = 30;
  localparam int WDC_GYR_BIT = 29;
  localparam int WDC_YR_BIT = 28;
  localparam int WDC_R_BIT = 27;
  localparam int WDC_QDALL_BIT = 26;
  localparam int WDC_PEN_BIT = 0;
  localparam int WDC_SRP_BIT = 2;
  localparam int WDC_MTYPE_LSB = 8;
  localparam int WDC_PMDALL_BIT = 10;
  localparam logic [10:0] WDC_PM_MAX_RST = 11'h400;
  localparam logic [10:0] WDC_PM_MIN_RST = 11'h080;
  localparam logic [10:0] WDC_PM_MUL_RST = 11'h020;
  localparam logic [10:0] WDC_Q_MAX_RST = 11'h080;
  localparam logic [10:0] WDC_Q_MIN_RST = 11'h009;
  localparam logic [10:0] WDC_Q_MUL_RST = 11'h010;
  localparam int WDC_QCFG_W = 33;
  localparam logic [32:0] WDC_QCFG_RST =
    {WDC_Q_MUL_RST, WDC_Q_MAX_RST, WDC_Q_MIN_RST};
  localparam int WDC_AVG_SHIFT = 3;
  localparam logic [15:0] WDC_LFSR_SEED = 16'hACE1;
  localparam logic [15:0] WDC_LFSR_TAPS = 16'hB400;
  typedef enum logic [1:0] {
    WDC_GREEN, WDC_YELLOW, WDC_RED, WDC_CRSV
  } wdc_colour_e;
  typedef enum logic [1:0] {
    WDC_MON_DROP, WDC_MON_GREEN, WDC_MON_YELLOW, WDC_MON_RED
  } wdc_mon_e;
endpackage

/* verilog/wred_drop_control.sv */
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// R01: Shared memory max threshold, reset 0x400.
// R02: Shared memory min threshold, reset 0x080.
// R03: Shared memory multiplier, reset 0x020.
// R04: Shared memory average readable, write ignored.
// R05: Per-queue max threshold, reset 0x080.
// R06: Per-queue min threshold, reset 0x009.
// R07: Per-queue multiplier, reset 0x010.
// R08: Selected queue average readable only.
// R09: Random drop only when enable set.
// R10: Flush clears counters on rising edge.
// R11: Protect all colours from dropping.
// R12: Protect yellow and red from dropping.
// R13: Protect red from dropping.
// R14: Drop-all above max, else probability.
// R15: Read-only 24-bit event counter per queue.
// R16: Nothing drops unless policing enabled.
// R17: Monitor type selects counted event.
// R18: Reservation frames exempt unless allowed.
// R19: No drop below min, rising above.
module wred_drop_control
  import wdc_pkg::*;
#(
  parameter int NPORT = 7,
  parameter int NQ = 4
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [WDC_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Port and queue pointer for the indexed registers
  input wire logic [2:0] sel_port,
  input wire logic [1:0] sel_queue,
  // Packet decision request
  input wire logic pkt_valid,
  input wire logic [2:0] pkt_port,
  input wire logic [1:0] pkt_queue,
  input wire logic [1:0] pkt_colour,
  input wire logic pkt_srp,
  input wire logic [10:0] pkt_q_depth,
  input wire logic [10:0] mem_depth,
  // Packet decision answer
  output logic dec_valid,
  output logic dec_drop
);
  localparam int DEPTH = NPORT * NQ;
  localparam int IW = $clog2(DEPTH);
  generate
    if (NPORT < 1 || NPORT > 8 || NQ < 1 || NQ > 4 || DEPTH < 2) begin : g_chk
      $error("port or queue count out of range");
    end
  endgenerate
  function automatic logic [IW-1:0] q_idx(input logic [2:0] p,
      input logic [1:0] q);
    q_idx = IW'(int'(p) * NQ + int'(q));
  endfunction
  // Moving average: a step of one eighth of the gap per sample.
  function automatic logic [10:0] avg_step(input logic [10:0] a,
      input logic [10:0] s);
    logic signed [12:0] d;
    d = $signed({2'b00, s}) - $signed({2'b00, a});
    avg_step = 11'({2'b00, a} + 13'(d >>> WDC_AVG_SHIFT));
  endfunction
  wdc_dec_if dec ();
  logic acc_wr, wr_police, wr_pm_thr, wr_pm_mul, wr_q_thr, wr_q_mul, wr_mon;
  logic rd_hit, flush_pulse, q_we, cnt_inc, cnt_any, s1_valid, s1_srp;
  logic [31:0] rd_val, prdata_r;
  logic police_en_r, allow_srp_r, pm_dall_r;
  wdc_mon_e mon_type_r;
  logic [10:0] pm_max_r, pm_min_r, pm_mul_r, pm_avg_r, s1_qavg;
  logic rde_r, flush_r, gyr_r, yr_r, rdis_r, qdall_r;
  logic [IW-1:0] sel_idx, pkt_idx, s1_idx, s2_idx;
  logic [WDC_QCFG_W-1:0] q_rd, q_cfg, q_wdata;
  logic [10:0] q_avg_r [DEPTH];
  logic [WDC_CNT_W-1:0] cnt_r [DEPTH];
  logic [WDC_CNT_W-1:0] cnt_sel, cnt_s2;
  wdc_colour_e s1_colour, s2_colour;
  assign sel_idx = q_idx(sel_port, sel_queue);
  assign pkt_idx = q_idx(pkt_port, pkt_queue);
  // The slave never stalls; indexed reads rely on the pointer being
  // steady one cycle before the setup phase.
  assign pready = 1'b1;
  assign acc_wr = psel && penable && pwrite;
  assign wr_police = acc_wr && paddr == WDC_POLICE_OFS;
  assign wr_pm_thr = acc_wr && paddr == WDC_PM_THR_OFS;
  assign wr_pm_mul = acc_wr && paddr == WDC_PM_MUL_OFS;
  assign wr_q_thr = acc_wr && paddr == WDC_Q_THR_OFS;
  assign wr_q_mul = acc_wr && paddr == WDC_Q_MUL_OFS;
  assign wr_mon = acc_wr && paddr == WDC_MON_OFS;
  assign cnt_sel = cnt_r[sel_idx];
  assign cnt_s2 = cnt_r[s2_idx];
  always_comb begin
    rd_hit = 1'b1;
    rd_val = 32'h0000_0000;
    if (paddr == WDC_POLICE_OFS) begin
      rd_val[WDC_PEN_BIT] = police_en_r;
      rd_val[WDC_SRP_BIT] = allow_srp_r;
      rd_val[WDC_MTYPE_LSB +: 2] = mon_type_r;
      rd_val[WDC_PMDALL_BIT] = pm_dall_r;
    end else if (paddr == WDC_PM_THR_OFS) begin
      rd_val[WDC_HI_LSB +: WDC_FW] = pm_max_r;
      rd_val[WDC_LO_LSB +: WDC_FW] = pm_min_r;
    end else if (paddr == WDC_PM_MUL_OFS) begin
      rd_val[WDC_HI_LSB +: WDC_FW] = pm_mul_r;
      rd_val[WDC_LO_LSB +: WDC_FW] = pm_avg_r; // R04
    end else if (paddr == WDC_Q_THR_OFS) begin
      rd_val[WDC_HI_LSB +: WDC_FW] = q_rd[21:11];
      rd_val[WDC_LO_LSB +: WDC_FW] = q_rd[10:0];
    end else if (paddr == WDC_Q_MUL_OFS) begin
      rd_val[WDC_HI_LSB +: WDC_FW] = q_rd[32:22];
      rd_val[WDC_LO_LSB +: WDC_FW] = q_avg_r[sel_idx]; // R08
    end else if (paddr == WDC_MON_OFS) begin
      rd_val[WDC_RDE_BIT] = rde_r;
      rd_val[WDC_FLUSH_BIT] = flush_r;
      rd_val[WDC_GYR_BIT] = gyr_r;
      rd_val[WDC_YR_BIT] = yr_r;
      rd_val[WDC_R_BIT] = rdis_r;
      rd_val[WDC_QDALL_BIT] = qdall_r;
      rd_val[WDC_CNT_W-1:0] = cnt_sel; // R15
    end else begin
      rd_hit = 1'b0;
    end
  end
  assign pslverr = psel && penable && !rd_hit;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata_r <= rd_val;
    end
  end
  assign prdata = prdata_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      police_en_r <= 1'b0;
      allow_srp_r <= 1'b0;
      mon_type_r <= WDC_MON_DROP;
      pm_dall_r <= 1'b0;
    end else if (wr_police) begin
      police_en_r <= pwdata[WDC_PEN_BIT]; // R16
      allow_srp_r <= pwdata[WDC_SRP_BIT]; // R18
      mon_type_r <= wdc_mon_e'(pwdata[WDC_MTYPE_LSB +: 2]); // R17
      pm_dall_r <= pwdata[WDC_PMDALL_BIT];
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pm_max_r <= WDC_PM_MAX_RST;
      pm_min_r <= WDC_PM_MIN_RST;
      pm_mul_r <= WDC_PM_MUL_RST;
    end else if (wr_pm_thr) begin
      pm_max_r <= pwdata[WDC_HI_LSB +: WDC_FW]; // R01
      pm_min_r <= pwdata[WDC_LO_LSB +: WDC_FW]; // R02
    end else if (wr_pm_mul) begin
      pm_mul_r <= pwdata[WDC_HI_LSB +: WDC_FW]; // R03
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pm_avg_r <= 11'h000;
    end else begin
      pm_avg_r <= avg_step(pm_avg_r, mem_depth); // R04
    end
  end
  assign flush_pulse = wr_mon && pwdata[WDC_FLUSH_BIT] && !flush_r; // R10
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rde_r <= 1'b0;
      flush_r <= 1'b0;
      gyr_r <= 1'b0;
      yr_r <= 1'b0;
      rdis_r <= 1'b0;
      qdall_r <= 1'b0;
    end else if (wr_mon) begin
      rde_r <= pwdata[WDC_RDE_BIT]; // R09
      flush_r <= pwdata[WDC_FLUSH_BIT];
      gyr_r <= pwdata[WDC_GYR_BIT]; // R11
      yr_r <= pwdata[WDC_YR_BIT]; // R12
      rdis_r <= pwdata[WDC_R_BIT]; // R13
      qdall_r <= pwdata[WDC_QDALL_BIT]; // R14
    end
  end
  // A queue write only replaces its own fields; the rest comes from the
  // selected entry's registered read data.
  assign q_we = wr_q_thr || wr_q_mul;
  assign q_wdata = wr_q_thr ?
    {q_rd[32:22], pwdata[WDC_HI_LSB +: WDC_FW], pwdata[WDC_FW-1:0]} : // R05
    {pwdata[WDC_HI_LSB +: WDC_FW], q_rd[21:0]}; // R07
  wdc_mem #(
    .W(WDC_QCFG_W),
    .D(DEPTH),
    .RST(WDC_QCFG_RST)
  ) u_qcfg (
    .pclk(pclk),
    .presetn(presetn),
    .we(q_we),
    .waddr(sel_idx),
    .wdata(q_wdata),
    .raddr_a(sel_idx),
    .rdata_a(q_rd),
    .raddr_b(pkt_idx),
    .rdata_b(q_cfg)
  );
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < DEPTH; i++) begin
        q_avg_r[i] <= 11'h000;
      end
    end else if (pkt_valid) begin
      q_avg_r[pkt_idx] <= avg_step(q_avg_r[pkt_idx], pkt_q_depth); // R08
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_valid <= 1'b0;
      s1_srp <= 1'b0;
      s1_colour <= WDC_GREEN;
      s1_idx <= '0;
      s1_qavg <= 11'h000;
      s2_colour <= WDC_GREEN;
      s2_idx <= '0;
    end else begin
      s1_valid <= pkt_valid;
      s1_srp <= pkt_srp;
      s1_colour <= wdc_colour_e'(pkt_colour);
      s1_idx <= pkt_idx;
      s1_qavg <= avg_step(q_avg_r[pkt_idx], pkt_q_depth);
      s2_colour <= s1_colour;
      s2_idx <= s1_idx;
    end
  end
  assign dec.req = s1_valid;
  assign dec.colour = s1_colour;
  assign dec.stream_reservation_frames = s1_srp;
  assign dec.en = police_en_r && rde_r; // R16
  assign dec.allow_srp = allow_srp_r;
  assign dec.gyr_dis = gyr_r;
  assign dec.yr_dis = yr_r;
  assign dec.r_dis = rdis_r;
  assign dec.q_dall = qdall_r;
  assign dec.pm_dall = pm_dall_r;
  assign dec.q_avg = s1_qavg;
  assign dec.q_min = q_cfg[10:0]; // R06
  assign dec.q_max = q_cfg[21:11]; // R05
  assign dec.q_mul = q_cfg[32:22]; // R07
  assign dec.pm_avg = pm_avg_r;
  assign dec.pm_min = pm_min_r;
  assign dec.pm_max = pm_max_r;
  assign dec.pm_mul = pm_mul_r;
  wdc_drop_calc u_calc (
    .pclk(pclk),
    .presetn(presetn),
    .dec(dec.calc)
  );
  assign dec_valid = dec.valid;
  assign dec_drop = dec.drop;
  always_comb begin
    case (mon_type_r)
      WDC_MON_DROP: cnt_inc = dec_valid && dec_drop; // R17
      WDC_MON_GREEN: cnt_inc = dec_valid && s2_colour == WDC_GREEN;
      WDC_MON_YELLOW: cnt_inc = dec_valid && s2_colour == WDC_YELLOW;
      default: cnt_inc = dec_valid && s2_colour == WDC_RED;
    endcase
  end
  // An event in the flush cycle is kept, so the entry restarts at one.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < DEPTH; i++) begin
        cnt_r[i] <= '0;
      end
    end else begin
      for (int i = 0; i < DEPTH; i++) begin
        if (flush_pulse) begin
          cnt_r[i] <= {23'h000000, cnt_inc && s2_idx == IW'(i)}; // R10
        end else if (cnt_inc && s2_idx == IW'(i)) begin
          cnt_r[i] <= cnt_r[i] + 24'h000001; // R15
        end
      end
    end
  end
  always_comb begin
    cnt_any = 1'b0;
    for (int i = 0; i < DEPTH; i++) begin
      cnt_any = cnt_any || (cnt_r[i] != '0);
    end
  end
  sequence s_q_thr_wr;
    wr_q_thr ##1 $stable(sel_idx);
  endsequence
  a_pm_thr_write: assert property (@(posedge pclk) disable iff (!presetn)
    wr_pm_thr |=> pm_max_r == $past(pwdata[26:16]) && // R01
    pm_min_r == $past(pwdata[10:0]))
    else $error("shared memory thresholds not written");
  a_pm_mul_write: assert property (@(posedge pclk) disable iff (!presetn)
    wr_pm_mul |=> pm_mul_r == $past(pwdata[26:16])) // R03
    else $error("shared memory multiplier not written");
  a_pm_avg_read: assert property (@(posedge pclk) disable iff (!presetn)
    psel && !penable && !pwrite && paddr == WDC_PM_MUL_OFS |=> // R04
    prdata[10:0] == $past(pm_avg_r) && prdata[31:27] == 5'h00)
    else $error("shared memory average not returned");
  a_q_thr_write: assert property (@(posedge pclk) disable iff (!presetn)
    s_q_thr_wr |=> q_rd[21:0] == // R05
    {$past(pwdata[26:16], 2), $past(pwdata[10:0], 2)})
    else $error("queue thresholds not written");
  a_rde_off: assert property (@(posedge pclk) disable iff (!presetn)
    s1_valid && !rde_r |=> dec_valid && !dec_drop) // R09
    else $error("drop while random drop disabled");
  a_police_off: assert property (@(posedge pclk) disable iff (!presetn)
    s1_valid && !police_en_r |=> !dec_drop) // R16
    else $error("drop while policing disabled");
  a_flush_clears: assert property (@(posedge pclk) disable iff (!presetn)
    flush_pulse && !cnt_inc |=> !cnt_any) // R10
    else $error("flush left a counter non-zero");
  a_cnt_step: assert property (@(posedge pclk) disable iff (!presetn)
    cnt_inc && !flush_pulse |=> // R17
    cnt_r[$past(s2_idx)] == $past(cnt_s2) + 24'h000001)
    else $error("event counter did not advance by one");
  a_dec_latency: assert property (@(posedge pclk) disable iff (!presetn)
    pkt_valid |-> ##2 dec_valid)
    else $error("decision not answered two cycles after request");
endmodule
`default_nettype wire
